/* File: hw/fps_map.svh */
// fps_map.svh: offsets, field layout, reset values and timing counts of the fetch sequencer
// assumes: included by bare name from the package and the design modules
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH
`define FPS_PC_W 10
`define FPS_PCL_W 8
`define FPS_PAGE_W 2
`define FPS_PC_RESET 10'h000
`define FPS_OFF_PCL 12'h000
`define FPS_OFF_CTRL 12'h004
`define FPS_OFF_STAT 12'h008
`define FPS_OFF_PCFULL 12'h00C
`define FPS_WAKE_FAST_CYC 16'h0080
`define FPS_WAKE_SLOW_CYC 16'h0002
`define FPS_WAKE_ON_CYC 16'h0002
`define FPS_SWITCH_CYC 16'h0080
`define FPS_SLOW_INTERNAL_OSCILLATOR_START_NS 500000
`define FPS_CLK_NS 8
`define FPS_CTRL_RUN 0
`define FPS_CTRL_SLOWSEL 1
`define FPS_CTRL_SLOWOFF 2
`define FPS_STAT_BUSY 0
`define FPS_STAT_SLOW 1
`define FPS_STAT_DUMMY 2
`define FPS_STAT_PH_LSB 4
`endif

/* File: hw/fps_pkg.sv */
// fps_pkg.sv: types shared by the fetch sequencer modules
// assumes: fps_map.svh holds every number
`include "fps_map.svh"
package fps_pkg;
   typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} fps_phase_t;
   typedef enum logic [2:0] {
      OP_SEQ, OP_JUMP, OP_CALL, OP_SKIP, OP_RET, OP_HALT
   } fps_op_t;
   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_HALT} fps_state_t;
endpackage

/* File: hw/fps_delay_cnt.sv */
// fps_delay_cnt.sv: loadable down counter timing wake-up and speed-switch delays
// assumes: single pclk domain; load wins over counting
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_delay_cnt import fps_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic load,
   input wire logic [31:0] count,
   // status
   output logic busy
);
   logic [31:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0;
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != 32'h0) begin
         cnt_q <= cnt_q - 32'h1;
      end
   end
   assign busy = (cnt_q != 32'h0);
endmodule

/* File: hw/fps_fetch_seq.sv */
// fps_fetch_seq.sv: instruction fetch pipeline and program counter sequencer
// assumes: program memory answers fetch_addr with instr_word in the same T1 slot;
// decode of the fetched word arrives on op_* inputs from core logic on pclk.
// Overview of operation
// RL1 - the clock is split into four phases that make one instruction cycle.
// RL2 - the counter advances at the start of the first phase while the next word is fetched.
// RL3 - fetch of the next word overlaps execution so plain instructions take one cycle.
// RL4 - jumps and calls take two instruction cycles, the second carrying out the branch.
// RL5 - the counter goes up by one after each instruction unless a branch is taken.
// RL6 - jump, call, interrupt and reset load the counter with the target.
// RL7 - a satisfied skip discards the prefetched word and inserts one dummy cycle.
// RL8 - only the low counter byte is visible to software, read and write; the code also reads the whole counter at FPS_OFF_PCFULL.
// RL9 - a write of the low byte jumps within the current 256-word page.
// RL10 - a low-byte write that branches inserts one dummy cycle for the refetch.
// RL11 - wake from clock-off waits 128 fast or 2 slow periods before running.
// RL12 - wake with the clock kept running waits 2 periods of the active clock.
// RL13 - a speed switch that starts the fast oscillator waits 128 of its periods.
// RL14 - wake with the slow oscillator stopped adds its start-up time.
// RL15 - after reset the counter is zero and fetching starts there.
// RL16 - the counter covers the whole 1K program space with upper bits as page index.
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_fetch_seq import fps_pkg::*; #(
   parameter int SLOW_INTERNAL_OSCILLATOR_START_CYC = (`FPS_SLOW_INTERNAL_OSCILLATOR_START_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // program memory
   output logic [`FPS_PC_W-1:0] fetch_addr,
   output logic fetch_req,
   input wire logic [13:0] instr_word,
   // decode and events from core
   input wire logic op_valid,
   input wire fps_op_t op_kind,
   input wire logic [`FPS_PC_W-1:0] op_target,
   input wire logic skip_taken,
   input wire logic irq_take,
   input wire logic [`FPS_PC_W-1:0] irq_vector,
   input wire logic [`FPS_PC_W-1:0] ret_addr,
   input wire logic wake_pin,
   // pipeline outputs
   output logic [1:0] phase,
   output logic [13:0] exec_word,
   output logic exec_valid,
   output logic [`FPS_PC_W-1:0] pc
);
   fps_phase_t ph_q;
   fps_state_t st_q;
   logic [`FPS_PC_W-1:0] pc_q;
   logic [13:0] ir_q;
   logic ir_ok_q;
   logic dummy_q;
   logic branch_pend_q;
   logic [`FPS_PC_W-1:0] branch_tgt_q;
   logic [2:0] ctrl_q;
   logic slow_q;
   logic pcl_wr_pend_q;
   logic [7:0] pcl_wr_q;
   logic [31:0] prdata_q;
   logic wake_s1_q, wake_s2_q;
   logic dly_load;
   logic [31:0] dly_count;
   logic dly_busy;
   logic apb_wr, apb_rd, addr_ok;
   logic t1;

   assign t1 = (ph_q == PH_T1) && (st_q == ST_RUN);

   // phase rotation only while running; clock-stopped states hold the phase at T1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= PH_T1;
      end else if (st_q == ST_RUN) begin
         unique case (ph_q) // RL1
            PH_T1: ph_q <= PH_T2;
            PH_T2: ph_q <= PH_T3;
            PH_T3: ph_q <= PH_T4;
            PH_T4: ph_q <= PH_T1;
         endcase
      end else begin
         ph_q <= PH_T1;
      end
   end

   // wake pin comes from outside, two flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= wake_pin;
         wake_s2_q <= wake_s1_q;
      end
   end

   // apb decode: zero wait states
   assign addr_ok = (paddr == `FPS_OFF_PCL) || (paddr == `FPS_OFF_CTRL) ||
                    (paddr == `FPS_OFF_STAT) || (paddr == `FPS_OFF_PCFULL);
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !pwrite && !penable;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // delay selection for wake and speed switch
   always_comb begin
      dly_load = 1'b0;
      dly_count = 32'h0;
      if (st_q == ST_HALT && wake_s2_q) begin
         dly_load = 1'b1;
         if (!ctrl_q[`FPS_CTRL_RUN]) begin
            if (slow_q) begin
               dly_count = 32'(`FPS_WAKE_SLOW_CYC); // RL11
               if (ctrl_q[`FPS_CTRL_SLOWOFF]) begin
                  dly_count = 32'(`FPS_WAKE_SLOW_CYC) + 32'(SLOW_INTERNAL_OSCILLATOR_START_CYC); // RL14
               end
            end else begin
               dly_count = 32'(`FPS_WAKE_FAST_CYC); // RL11
            end
         end else begin
            dly_count = 32'(`FPS_WAKE_ON_CYC); // RL12
         end
      end else if (apb_wr && paddr == `FPS_OFF_CTRL && st_q == ST_RUN &&
                   pwdata[`FPS_CTRL_SLOWSEL] != slow_q && !pwdata[`FPS_CTRL_SLOWSEL]) begin
         dly_load = 1'b1;
         dly_count = 32'(`FPS_SWITCH_CYC); // RL13
      end
   end

   fps_delay_cnt u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .load(dly_load),
      .count(dly_count),
      .busy(dly_busy)
   );

   // sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_RUN;
      end else begin
         unique case (st_q)
            ST_RUN: begin
               if (dly_load) begin
                  st_q <= ST_WAIT;
               end else if (ph_q == PH_T4 && exec_valid && op_valid && op_kind == OP_HALT) begin
                  st_q <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (dly_load) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!dly_busy && !dly_load) begin
                  st_q <= ST_RUN;
               end
            end
            default: st_q <= ST_RUN;
         endcase
      end
   end

   // control register and clock source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 3'h0;
         slow_q <= 1'b0;
      end else if (apb_wr && paddr == `FPS_OFF_CTRL) begin
         ctrl_q <= pwdata[2:0];
         slow_q <= pwdata[`FPS_CTRL_SLOWSEL];
      end
   end

   // low-byte write is held until the next T1 so the pipeline sees it at a clean boundary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcl_wr_pend_q <= 1'b0;
         pcl_wr_q <= 8'h00;
      end else if (apb_wr && paddr == `FPS_OFF_PCL) begin
         pcl_wr_pend_q <= 1'b1;
         pcl_wr_q <= pwdata[7:0];
      end else if (t1) begin
         pcl_wr_pend_q <= 1'b0;
      end
   end

   // program counter, fetch and dummy insertion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= `FPS_PC_RESET; // RL15
         ir_q <= 14'h0000;
         ir_ok_q <= 1'b0;
         dummy_q <= 1'b0;
         branch_pend_q <= 1'b0;
         branch_tgt_q <= `FPS_PC_RESET;
      end else begin
         if (ph_q == PH_T4 && st_q == ST_RUN && exec_valid && op_valid &&
             (op_kind == OP_JUMP || op_kind == OP_CALL || op_kind == OP_RET)) begin
            branch_pend_q <= 1'b1; // RL4
            branch_tgt_q <= (op_kind == OP_RET) ? ret_addr : op_target;
         end
         if (t1) begin
            if (irq_take) begin
               pc_q <= irq_vector; // RL6
               ir_ok_q <= 1'b0;
               dummy_q <= 1'b1;
            end else if (branch_pend_q) begin
               pc_q <= branch_tgt_q; // RL6
               branch_pend_q <= 1'b0;
               ir_ok_q <= 1'b0; // RL4
               dummy_q <= 1'b1;
            end else if (pcl_wr_pend_q) begin
               pc_q <= {pc_q[`FPS_PC_W-1:`FPS_PCL_W], pcl_wr_q}; // RL9
               ir_ok_q <= 1'b0; // RL10
               dummy_q <= 1'b1;
            end else if (skip_taken && exec_valid) begin
               pc_q <= pc_q + 10'h001;
               ir_ok_q <= 1'b0; // RL7
               dummy_q <= 1'b1;
            end else begin
               pc_q <= pc_q + 10'h001; // RL2 RL5
               ir_q <= instr_word; // RL3
               ir_ok_q <= 1'b1;
               dummy_q <= 1'b0;
            end
         end
      end
   end

   // a halt makes the remaining prefetch stale only after wake; it is kept
   assign fetch_addr = pc_q; // RL16
   assign fetch_req = t1; // RL2
   assign exec_word = ir_q;
   assign exec_valid = ir_ok_q && (st_q == ST_RUN);
   assign phase = ph_q;
   assign pc = pc_q;

   // read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (apb_rd) begin
         prdata_q <= 32'h0;
         if (paddr == `FPS_OFF_PCL) begin
            prdata_q <= {24'h0, pc_q[`FPS_PCL_W-1:0]}; // RL8
         end else if (paddr == `FPS_OFF_CTRL) begin
            prdata_q <= {29'h0, ctrl_q};
         end else if (paddr == `FPS_OFF_STAT) begin
            prdata_q <= {26'h0, ph_q, 1'b0, dummy_q, slow_q, st_q != ST_RUN};
         end else if (paddr == `FPS_OFF_PCFULL) begin
            prdata_q <= {22'h0, pc_q};
         end
      end
   end
   assign prdata = prdata_q;

   // assertions
   property p_phase_order;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_RUN && ph_q == PH_T1) ##1 (st_q == ST_RUN) |-> ph_q == PH_T2;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("phase order broken"); // RL1

   property p_pc_inc;
      @(posedge pclk) disable iff (!presetn)
      (t1 && !irq_take && !branch_pend_q && !pcl_wr_pend_q) |=> pc_q == $past(pc_q) + 10'h001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not increment"); // RL5

   property p_pc_hold;
      @(posedge pclk) disable iff (!presetn)
      !t1 |=> pc_q == $past(pc_q);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved outside first phase"); // RL2

   property p_skip_dummy;
      @(posedge pclk) disable iff (!presetn)
      (t1 && skip_taken && exec_valid) |=> dummy_q && !ir_ok_q;
   endproperty
   a_skip_dummy: assert property (p_skip_dummy) else $error("skip without dummy"); // RL7

   property p_page_keep;
      @(posedge pclk) disable iff (!presetn)
      (t1 && pcl_wr_pend_q && !irq_take && !branch_pend_q) |=>
         pc_q[9:8] == $past(pc_q[9:8]) && pc_q[7:0] == $past(pcl_wr_q) && dummy_q;
   endproperty
   a_page_keep: assert property (p_page_keep) else $error("low byte jump left page"); // RL9

   property p_branch_two;
      @(posedge pclk) disable iff (!presetn)
      (t1 && branch_pend_q && !irq_take) |=> pc_q == $past(branch_tgt_q) && !exec_valid;
   endproperty
   a_branch_two: assert property (p_branch_two) else $error("branch not loaded"); // RL4

   property p_wake_fast;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_HALT && wake_s2_q && !ctrl_q[0] && !slow_q) |=> (st_q == ST_WAIT) [*8];
   endproperty
   a_wake_fast: assert property (p_wake_fast) else $error("fast wake too short"); // RL11

   property p_wake_on;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_HALT && wake_s2_q && ctrl_q[0]) |=> ##3 st_q == ST_RUN;
   endproperty
   a_wake_on: assert property (p_wake_on) else $error("wake with clock on mistimed"); // RL12

   property p_reset_pc;
      @(posedge pclk) $rose(presetn) |-> pc_q == 10'h000;
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset"); // RL15

   property p_wake_slow;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_HALT && wake_s2_q && !ctrl_q[`FPS_CTRL_RUN] && slow_q &&
         !ctrl_q[`FPS_CTRL_SLOWOFF]) |=> (st_q == ST_WAIT) [*3] ##1 st_q == ST_RUN;
   endproperty
   a_wake_slow: assert property (p_wake_slow) else $error("slow wake mistimed"); // RL11

   property p_switch_wait;
      @(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == `FPS_OFF_CTRL && st_q == ST_RUN && slow_q &&
         !pwdata[`FPS_CTRL_SLOWSEL]) |=> (st_q == ST_WAIT) [*8];
   endproperty
   a_switch_wait: assert property (p_switch_wait) else $error("speed switch too short"); // RL13

   property p_irq_load;
      @(posedge pclk) disable iff (!presetn)
      (t1 && irq_take) |=> pc_q == $past(irq_vector) && dummy_q && !exec_valid;
   endproperty
   a_irq_load: assert property (p_irq_load) else $error("interrupt vector not loaded"); // RL6

   property p_fetch_load;
      @(posedge pclk) disable iff (!presetn)
      (t1 && !irq_take && !branch_pend_q && !pcl_wr_pend_q &&
         !(skip_taken && exec_valid)) |=> ir_q == $past(instr_word) && ir_ok_q;
   endproperty
   a_fetch_load: assert property (p_fetch_load) else $error("fetched word not kept"); // RL3
endmodule

/* File: sim/fps_prog_mem.sv */
// fps_prog_mem.sv: program memory model feeding words to the fetch sequencer
// assumes: word answered combinationally in the T1 slot that raises fetch_req
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_prog_mem (
   // clock
   input wire logic pclk,
   // fetch port
   input wire logic fetch_req,
   input wire logic [`FPS_PC_W-1:0] fetch_addr,
   output logic [13:0] instr_word
);
   logic [13:0] junk_q = 14'h0000;
   // outside fetch the bus moves every cycle, so a stale word cannot pass as valid
   always_ff @(posedge pclk) junk_q <= junk_q + 14'h1235;
   assign instr_word = fetch_req ? {fetch_addr, 4'h5} : junk_q;
endmodule

/* File: sim/fps_fetch_seq_bench.sv */
// fps_fetch_seq_bench.sv: self-checking bench of the fetch sequencer
// assumes: fps_prog_mem as program memory; apb master and core decode driven here
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_fetch_seq_bench import fps_pkg::*; ;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 1;
   logic skip_taken = 0, irq_take = 0, wake_pin = 0, pready, pslverr, fetch_req, exec_valid, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
   logic [`FPS_PC_W-1:0] fetch_addr, pc, t, op_target = 0, irq_vector = 0, ret_addr = 0;
   logic [13:0] instr_word, exec_word;
   logic [1:0] phase, ep;
   logic [7:0] x;
   fps_op_t op_kind = OP_SEQ;
   int num_errors = 0, n_tests = 0, n = 0, lows = 0;
   always #4 pclk = ~pclk;
   // small start-up count keeps the stopped-oscillator wake short
   fps_fetch_seq #(.SLOW_INTERNAL_OSCILLATOR_START_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch_addr(fetch_addr), .fetch_req(fetch_req),
      .instr_word(instr_word), .op_valid(op_valid), .op_kind(op_kind), .op_target(op_target),
      .skip_taken(skip_taken), .irq_take(irq_take), .irq_vector(irq_vector),
      .ret_addr(ret_addr), .wake_pin(wake_pin), .phase(phase), .exec_word(exec_word),
      .exec_valid(exec_valid), .pc(pc));
   fps_prog_mem mem (.pclk(pclk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .instr_word(instr_word));
   always @(negedge pclk) if (exec_valid !== 1'b1) lows++;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wait_ph(input logic [1:0] p);
      n = 0;
      do begin
         @(posedge pclk);
         #1 n++;
      end while (phase !== p && n < 8);
   endtask
   // op shown in T4, skip and interrupt in the following T1; lows counted from that T4
   task issue(input fps_op_t k, input logic [`FPS_PC_W-1:0] tg, input logic s, input logic i);
      wait_ph(2);
      @(posedge pclk);
      op_kind <= k; op_target <= tg; lows = 0;
      @(posedge pclk);
      op_kind <= OP_SEQ; skip_taken <= s; irq_take <= i;
      @(posedge pclk);
      skip_taken <= 0; irq_take <= 0;
      @(negedge pclk);
   endtask
   function logic [`FPS_PC_W-1:0] in_page(input logic [`FPS_PC_W-1:0] p, input logic [7:0] b);
      return {p[`FPS_PC_W-1:8], b};
   endfunction
   // wake delay measured from the pin to the first valid execute slot
   task wake(input logic [31:0] c, input int lo);
      apb(1, `FPS_OFF_CTRL, c);
      issue(OP_HALT, 0, 0, 0);
      repeat (8) @(posedge pclk);
      apb(0, `FPS_OFF_STAT, 0);
      chk(rd[`FPS_STAT_BUSY], 1);
      apb(0, `FPS_OFF_PCL, 0);
      rd2 = rd;
      apb(0, `FPS_OFF_PCFULL, 0);
      chk(rd2[7:0], pc[7:0]);
      chk(rd[`FPS_PC_W-1:0], pc);
      wake_pin <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         #1 n++;
      end while (exec_valid !== 1'b1 && n < 400);
      @(posedge pclk);
      wake_pin <= 0;
      chk(n >= lo + 2 && n <= lo + 6, 1);
   endtask
   initial begin
      void'($urandom(32'h7AE42ADA));
      repeat (10) @(posedge pclk);
      chk(pc, `FPS_PC_RESET);
      chk(phase, 0);
      presetn <= 1;
      wait_ph(0);
      ep = 0;
      repeat (8) begin
         @(posedge pclk);
         #1 ep++;
         chk(phase, ep);
         chk(fetch_req, ep == 0);
      end
      repeat (3) begin
         wait_ph(1);
         t = pc;
         chk(fetch_addr, t);
         chk(exec_word, {t - 10'h001, 4'h5});
         wait_ph(1);
         chk(pc, t + 1);
      end
      issue(OP_SEQ, 0, 0, 0);
      repeat (13) @(negedge pclk);
      chk(lows, 0);
      @(posedge pclk);
      op_valid <= 1'b0;
      issue(OP_JUMP, 10'h3C0, 0, 0);
      @(posedge pclk);
      op_valid <= 1'b1;
      repeat (12) @(negedge pclk);
      chk(lows, 0);
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         ret_addr <= 10'($urandom);
         irq_vector <= 10'($urandom);
         t = 10'($urandom);
         @(posedge pclk);
         t = (i == 2) ? ret_addr : (i == 3) ? irq_vector : t;
         issue((i == 0) ? OP_JUMP : (i == 1) ? OP_CALL : (i == 2) ? OP_RET : OP_SEQ, t, 0, i == 3);
         chk(pc == t || pc == t + 1, 1);
         repeat (13) @(negedge pclk);
         chk(lows, 4);
      end
      issue(OP_SKIP, 0, 1, 0);
      repeat (13) @(negedge pclk);
      chk(lows, 4);
      x = 8'($urandom_range(0, 200));
      t = pc;
      lows = 0;
      apb(1, `FPS_OFF_PCL, {24'h0, x});
      repeat (14) @(negedge pclk);
      chk(lows, 4);
      chk(pc - in_page(t, x) <= 6, 1);
      apb(1, 12'h010, 32'h0000_00FF);
      chk(err, 1);
      apb(0, 12'h010, 0);
      chk(rd, 0);
      wake(32'h0, `FPS_WAKE_FAST_CYC);
      wake(32'h1, `FPS_WAKE_ON_CYC);
      wake(32'h2, `FPS_WAKE_SLOW_CYC);
      wake(32'h6, `FPS_WAKE_SLOW_CYC + 4);
      apb(1, `FPS_OFF_CTRL, 32'h0);
      n = 0;
      do begin
         apb(0, `FPS_OFF_STAT, 0);
         n += 3;
      end while (rd[`FPS_STAT_BUSY] === 1'b1 && n < 600);
      chk(n >= `FPS_SWITCH_CYC - 8 && n <= `FPS_SWITCH_CYC + 32, 1);
      tally_and_finish;
   end
   initial begin
      #(`FPS_CLK_NS * 20000);
      num_errors++;
      tally_and_finish;
   end
endmodule
